/* include/valve_ctrl_pkg.sv */
// Register map, codes, timing and carrier types of the valve control bank.
package valve_ctrl_pkg;

   // Integer holding registers (one 16-bit word each).
   localparam logic [15:0] ADDR_DIGITAL_SETPOINT = 16'h9c63;
   localparam logic [15:0] ADDR_DIGITAL_POSITION_COMMAND = 16'h9c64;
   localparam logic [15:0] ADDR_MODE_SOURCE_SELECT = 16'h9c65;
   localparam logic [15:0] ADDR_DIGITAL_OPERATING_MODE = 16'h9c66;
   localparam logic [15:0] ADDR_CONTROL_VARIABLE_SELECT = 16'h9c67;
   localparam logic [15:0] ADDR_SETPOINT_SOURCE_SELECT = 16'h9c69;
   localparam logic [15:0] ADDR_ANALOG_INPUT_POLARITY = 16'h9c6e;
   localparam logic [15:0] ADDR_TRIP_HOLD_SECONDS = 16'h9c6f;
   localparam logic [15:0] ADDR_REMOTE_TIMEOUT_SECONDS = 16'h9cad;

   // Float registers, two words each, addressed by the first.
   localparam logic [15:0] ADDR_AUX_INPUT_FULL_SCALE = 16'h9de5;
   localparam logic [15:0] ADDR_DELTA_PRESSURE_FULL_SCALE = 16'h9de7;
   localparam logic [15:0] ADDR_LIQUID_FLOW_FULL_SCALE = 16'h9de9;
   localparam logic [15:0] ADDR_GAS_FLOW_FULL_SCALE = 16'h9deb;
   localparam logic [15:0] ADDR_UPSTREAM_PRESSURE_FULL_SCALE = 16'h9ded;
   localparam logic [15:0] ADDR_DOWNSTREAM_PRESSURE_FULL_SCALE = 16'h9def;
   localparam logic [15:0] ADDR_TEMPERATURE_FULL_SCALE = 16'h9df1;
   localparam logic [15:0] ADDR_TEMPERATURE_MINIMUM_SCALE = 16'h9df3;
   localparam logic [15:0] ADDR_TRIP_RAMP_RATE = 16'h9e2b;
   localparam logic [15:0] ADDR_REMOTE_OPERATING_MODE = 16'h9eff;
   localparam logic [15:0] ADDR_REMOTE_SETPOINT_COMMAND = 16'h9f01;

   localparam int INT_COUNT = 9;
   localparam int FLOAT_COUNT = 11;
   localparam logic [3:0] IDX_DSP = 4'h0;
   localparam logic [3:0] IDX_DPOS = 4'h1;
   localparam logic [3:0] IDX_MSRC = 4'h2;
   localparam logic [3:0] IDX_DMODE = 4'h3;
   localparam logic [3:0] IDX_CVSEL = 4'h4;
   localparam logic [3:0] IDX_SPSRC = 4'h5;
   localparam logic [3:0] IDX_POL = 4'h6;
   localparam logic [3:0] IDX_HOLD = 4'h7;
   localparam logic [3:0] IDX_TMO = 4'h8;
   localparam logic [3:0] IDX_AUX_FS = 4'h0;
   localparam logic [3:0] IDX_DP_FS = 4'h1;
   localparam logic [3:0] IDX_LIQ_FS = 4'h2;
   localparam logic [3:0] IDX_GAS_FS = 4'h3;
   localparam logic [3:0] IDX_UP_FS = 4'h4;
   localparam logic [3:0] IDX_DN_FS = 4'h5;
   localparam logic [3:0] IDX_TEMP_FS = 4'h6;
   localparam logic [3:0] IDX_TEMP_MIN = 4'h7;
   localparam logic [3:0] IDX_RAMP = 4'h8;
   localparam logic [3:0] IDX_RMODE = 4'h9;
   localparam logic [3:0] IDX_RSP = 4'ha;

   // Register values with a meaning.
   localparam logic [15:0] MSRC_DIGITAL = 16'h0000;
   localparam logic [15:0] MSRC_DISCRETE = 16'h0001;
   localparam logic [15:0] MSRC_REMOTE = 16'h0002;
   localparam logic [15:0] DMODE_CALIBRATION = 16'h0000;
   localparam logic [15:0] DMODE_MANUAL = 16'h0001;
   localparam logic [15:0] DMODE_AUTO = 16'h0002;
   localparam logic [31:0] RMODE_MANUAL = 32'h0000_0000;
   localparam logic [31:0] RMODE_AUTO = 32'h42c8_0000;
   localparam logic [15:0] SPSRC_ANALOG = 16'h0000;
   localparam logic [15:0] SPSRC_DIGITAL = 16'h0001;
   localparam logic [15:0] SPSRC_REMOTE = 16'h0002;
   localparam logic [15:0] POL_NORMAL = 16'h0001;
   localparam logic [15:0] POL_INVERTED = 16'h0002;
   localparam logic [15:0] CV_LIQUID = 16'h0001;
   localparam logic [15:0] CV_UPSTREAM = 16'h0002;
   localparam logic [15:0] CV_DOWNSTREAM = 16'h0003;
   localparam logic [15:0] CV_DELTA = 16'h0004;
   localparam logic [15:0] CV_TEMPERATURE = 16'h0005;
   localparam logic [15:0] CV_GAS = 16'h0006;
   localparam logic [15:0] CV_AUX = 16'h0007;

   // Scaled integer end points: 0 is -12.5 percent, 9999 is 112.5 percent.
   localparam logic [15:0] SCALED_MIN = 16'h0000;
   localparam logic [15:0] SCALED_MAX = 16'h270f;
   localparam logic [15:0] ANALOG_FULL = 16'hffff;
   localparam logic [31:0] FLOAT_ZERO = 32'h0000_0000;
   localparam int FLOAT_SIGN = 31;

   // Seconds counted in system clock cycles.
   localparam longint CLK_PERIOD_NS = 25;
   localparam longint SECOND_NS = 1000000000;
   localparam int SECOND_CYCLES_DEFAULT = int'(SECOND_NS / CLK_PERIOD_NS);

   // Access word counts.
   localparam logic [1:0] WORDS_INT = 2'h1;
   localparam logic [1:0] WORDS_FLOAT = 2'h2;

   typedef enum logic [2:0] {
      MODE_TEST = 3'b001,
      MODE_MANUAL = 3'b010,
      MODE_AUTO = 3'b100
   } op_mode_t;

   typedef enum logic [2:0] {
      WD_RUN = 3'b001,
      WD_HOLD = 3'b010,
      WD_RAMP = 3'b100
   } watchdog_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [1:0] words;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic error;
      logic [31:0] rdata;
   } reg_resp_t;

   typedef struct packed {
      logic [1:0] source;
      logic isSetpoint;
      logic isFloat;
      logic [31:0] value;
      logic [31:0] scaleMax;
      logic [31:0] scaleMin;
   } command_t;

   typedef struct packed {
      logic hold;
      logic ramp;
      logic rampOpen;
      logic [31:0] rampRate;
   } trip_t;

endpackage

/* src/valve_mode_setpoint_control.sv */
// Mode, setpoint source, bumpless transfer and loss-of-command logic of the control valve.
//
// Summary of operation
// - Three operating modes exist: manual positioner, automatic controller, offline test.
// - Test mode freezes indicated values and ignores every setpoint or command change.
// - Start in test; leave it only when auto or manual is explicitly set or mode source 1 (discrete) is written.
// - Mode source register: 0 digital register, 1 discrete input, 2 remote float.
// - Digital mode register: 0 calibration, 1 manual, 2 automatic.
// - Each write of 2 to digital mode with mode source 0 (digital) copies process variable into digital setpoint.
// - Discrete source: energized input means automatic, de-energized means manual.
// - Remote source: remote mode float 0 means manual, 100 means automatic.
// - Remote source: bumpless transfer only when the remote mode value changes.
// - Setpoint source register: 0 analog loop, 1 digital integers, 2 remote float.
// - Digital source: setpoint register in automatic, position command register in manual.
// - Digital integers span 0 as minus 12.5 percent to 9999 as 112.5 percent.
// - Position command: 0 percent closed, 100 percent open.
// - Analog source drives command or setpoint; polarity 1 normal, 2 inverted.
// - Remote source: float gives setpoint percent of maximum or position percent open.
// - Remote source: no update within timeout seconds trips loss of command.
// - On trip, hold last setpoint or position for the hold-time seconds.
// - After the hold, ramp at the float rate; negative closes, positive opens.
// - Control-variable register picks the full-scale register for every source.
// - Codes 1..7 pick liquid, upstream, downstream, delta, temperature, gas, auxiliary.
// - Temperature also uses its own minimum-scale float as lower bound.
// - Floats take two consecutive words; a one-word float request is an error.
`timescale 1ns/1ps

module valve_mode_setpoint_control #(
   parameter int SECOND_CYCLES = valve_ctrl_pkg::SECOND_CYCLES_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire valve_ctrl_pkg::reg_req_t regReq,
   output valve_ctrl_pkg::reg_resp_t regResp,
   input wire logic discreteInput,
   input wire logic [15:0] analogInput,
   input wire logic [15:0] processVariable,
   output valve_ctrl_pkg::op_mode_t opMode,
   output valve_ctrl_pkg::command_t command,
   output valve_ctrl_pkg::trip_t trip,
   output logic [15:0] indicatedPv
);
   import valve_ctrl_pkg::*;

   if (SECOND_CYCLES < 1) begin : g_check
      $error("SECOND_CYCLES must be at least one");
   end

   logic [15:0] intReg_q [INT_COUNT];
   logic [31:0] floatReg_q [FLOAT_COUNT];
   op_mode_t mode_q;
   op_mode_t mode_d;
   watchdog_t wd_q;
   logic testLatch_q;
   reg_resp_t resp_q;
   command_t cmd_q;
   command_t cmd_d;
   trip_t trip_q;
   logic [15:0] pv_q;
   logic [31:0] secCnt_q;
   logic [15:0] elapsed_q;

   // Address decode helpers, shared by the write and read paths.
   function automatic logic [4:0] intIndex(input logic [15:0] a);
      case (a)
         ADDR_DIGITAL_SETPOINT: intIndex = {1'b1, IDX_DSP};
         ADDR_DIGITAL_POSITION_COMMAND: intIndex = {1'b1, IDX_DPOS};
         ADDR_MODE_SOURCE_SELECT: intIndex = {1'b1, IDX_MSRC};
         ADDR_DIGITAL_OPERATING_MODE: intIndex = {1'b1, IDX_DMODE};
         ADDR_CONTROL_VARIABLE_SELECT: intIndex = {1'b1, IDX_CVSEL};
         ADDR_SETPOINT_SOURCE_SELECT: intIndex = {1'b1, IDX_SPSRC};
         ADDR_ANALOG_INPUT_POLARITY: intIndex = {1'b1, IDX_POL};
         ADDR_TRIP_HOLD_SECONDS: intIndex = {1'b1, IDX_HOLD};
         ADDR_REMOTE_TIMEOUT_SECONDS: intIndex = {1'b1, IDX_TMO};
         default: intIndex = 5'h00;
      endcase
   endfunction

   function automatic logic [4:0] floatIndex(input logic [15:0] a);
      case (a)
         ADDR_AUX_INPUT_FULL_SCALE: floatIndex = {1'b1, IDX_AUX_FS};
         ADDR_DELTA_PRESSURE_FULL_SCALE: floatIndex = {1'b1, IDX_DP_FS};
         ADDR_LIQUID_FLOW_FULL_SCALE: floatIndex = {1'b1, IDX_LIQ_FS};
         ADDR_GAS_FLOW_FULL_SCALE: floatIndex = {1'b1, IDX_GAS_FS};
         ADDR_UPSTREAM_PRESSURE_FULL_SCALE: floatIndex = {1'b1, IDX_UP_FS};
         ADDR_DOWNSTREAM_PRESSURE_FULL_SCALE: floatIndex = {1'b1, IDX_DN_FS};
         ADDR_TEMPERATURE_FULL_SCALE: floatIndex = {1'b1, IDX_TEMP_FS};
         ADDR_TEMPERATURE_MINIMUM_SCALE: floatIndex = {1'b1, IDX_TEMP_MIN};
         ADDR_TRIP_RAMP_RATE: floatIndex = {1'b1, IDX_RAMP};
         ADDR_REMOTE_OPERATING_MODE: floatIndex = {1'b1, IDX_RMODE};
         ADDR_REMOTE_SETPOINT_COMMAND: floatIndex = {1'b1, IDX_RSP};
         default: floatIndex = 5'h00;
      endcase
   endfunction

   // Request classification.
   logic [4:0] iHit;
   logic [4:0] fHit;
   logic intOk;
   logic floatOk;
   logic wrInt;
   logic wrFloat;
   logic testMode;
   logic setpointWriteBlocked;
   logic digitalAutoWrite;
   logic remoteModeChange;
   logic remoteSpWrite;

   assign iHit = intIndex(regReq.addr);
   assign fHit = floatIndex(regReq.addr);
   assign intOk = iHit[4] && (regReq.words == WORDS_INT);
   assign floatOk = fHit[4] && (regReq.words == WORDS_FLOAT);
   assign wrInt = regReq.valid && regReq.write && intOk;
   assign wrFloat = regReq.valid && regReq.write && floatOk;
   assign testMode = (mode_q == MODE_TEST);
   // Host writes to setpoint and command registers are ignored while offline.
   assign setpointWriteBlocked = testMode;
   assign digitalAutoWrite = wrInt && (iHit[3:0] == IDX_DMODE)
      && (regReq.wdata[15:0] == DMODE_AUTO)
      && (intReg_q[IDX_MSRC] == MSRC_DIGITAL);
   assign remoteModeChange = wrFloat && (fHit[3:0] == IDX_RMODE)
      && (regReq.wdata != floatReg_q[IDX_RMODE])
      && (intReg_q[IDX_MSRC] == MSRC_REMOTE);
   assign remoteSpWrite = wrFloat && (fHit[3:0] == IDX_RSP) && !setpointWriteBlocked;

   // The digital setpoint also takes bumpless transfers.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < INT_COUNT; i++) begin
            intReg_q[i] <= 16'h0000;
         end
         intReg_q[IDX_POL] <= POL_NORMAL;
      end else begin
         if (wrInt) begin
            if (!(setpointWriteBlocked && (iHit[3:0] == IDX_DSP || iHit[3:0] == IDX_DPOS))) begin
               intReg_q[iHit[3:0]] <= regReq.wdata[15:0];
            end
         end
         if (digitalAutoWrite || remoteModeChange) begin
            intReg_q[IDX_DSP] <= processVariable;
         end
      end
   end

   // Float register storage.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < FLOAT_COUNT; i++) begin
            floatReg_q[i] <= FLOAT_ZERO;
         end
      end else if (wrFloat) begin
         if (!(setpointWriteBlocked && fHit[3:0] == IDX_RSP)) begin
            floatReg_q[fHit[3:0]] <= regReq.wdata;
         end
      end
   end

   // Answer one cycle later; unmapped or wrong-width access is an error.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         resp_q <= '0;
      end else begin
         resp_q.valid <= regReq.valid;
         resp_q.error <= regReq.valid && !intOk && !floatOk;
         if (regReq.valid && !regReq.write && intOk) begin
            resp_q.rdata <= {16'h0000, intReg_q[iHit[3:0]]};
         end else if (regReq.valid && !regReq.write && floatOk) begin
            resp_q.rdata <= floatReg_q[fHit[3:0]];
         end else begin
            resp_q.rdata <= 32'h0000_0000;
         end
      end
   end

   // Keeps a freshly powered unit offline until a mode is set.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         testLatch_q <= 1'b1;
      end else if (wrInt && iHit[3:0] == IDX_DMODE) begin
         testLatch_q <= !(regReq.wdata[15:0] == DMODE_MANUAL
            || regReq.wdata[15:0] == DMODE_AUTO);
      end else if (wrFloat && fHit[3:0] == IDX_RMODE) begin
         testLatch_q <= !(regReq.wdata == RMODE_MANUAL || regReq.wdata == RMODE_AUTO);
      end else if (wrInt && iHit[3:0] == IDX_MSRC && regReq.wdata[15:0] == MSRC_DISCRETE) begin
         testLatch_q <= 1'b0;
      end
   end

   // Undefined mode-source codes leave the mode unchanged; writing an undefined digital or remote mode code forces test.
   always_comb begin
      mode_d = mode_q;
      if (testLatch_q) begin
         mode_d = MODE_TEST;
      end else begin
         case (intReg_q[IDX_MSRC])
            MSRC_DIGITAL: begin
               case (intReg_q[IDX_DMODE])
                  DMODE_CALIBRATION: mode_d = MODE_TEST;
                  DMODE_MANUAL: mode_d = MODE_MANUAL;
                  DMODE_AUTO: mode_d = MODE_AUTO;
                  default: mode_d = mode_q;
               endcase
            end
            MSRC_DISCRETE: begin
               mode_d = discreteInput ? MODE_AUTO : MODE_MANUAL;
            end
            MSRC_REMOTE: begin
               if (floatReg_q[IDX_RMODE] == RMODE_AUTO) begin
                  mode_d = MODE_AUTO;
               end else if (floatReg_q[IDX_RMODE] == RMODE_MANUAL) begin
                  mode_d = MODE_MANUAL;
               end else begin
                  mode_d = mode_q;
               end
            end
            default: mode_d = mode_q;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mode_q <= MODE_TEST;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Loss-of-command watchdog, counted in whole seconds.
   logic remoteActive;
   logic secondTick;
   assign remoteActive = (intReg_q[IDX_SPSRC] == SPSRC_REMOTE) && !testMode;
   assign secondTick = (secCnt_q == 32'(SECOND_CYCLES - 1));

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         secCnt_q <= 32'h0000_0000;
         elapsed_q <= 16'h0000;
         wd_q <= WD_RUN;
      end else if (!remoteActive || remoteSpWrite) begin
         secCnt_q <= 32'h0000_0000;
         elapsed_q <= 16'h0000;
         wd_q <= WD_RUN;
      end else begin
         secCnt_q <= secondTick ? 32'h0000_0000 : secCnt_q + 32'h0000_0001;
         case (wd_q)
            WD_RUN: begin
               if (intReg_q[IDX_TMO] != 16'h0000 && elapsed_q >= intReg_q[IDX_TMO]) begin
                  wd_q <= WD_HOLD;
                  elapsed_q <= 16'h0000;
               end else if (secondTick) begin
                  elapsed_q <= elapsed_q + 16'h0001;
               end
            end
            WD_HOLD: begin
               if (elapsed_q >= intReg_q[IDX_HOLD]) begin
                  wd_q <= WD_RAMP;
               end else if (secondTick) begin
                  elapsed_q <= elapsed_q + 16'h0001;
               end
            end
            WD_RAMP: wd_q <= WD_RAMP;
            default: wd_q <= WD_RUN;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         trip_q <= '0;
      end else begin
         trip_q.hold <= (wd_q == WD_HOLD);
         trip_q.ramp <= (wd_q == WD_RAMP);
         // Sign bit of the rate float decides direction: clear opens unless the rate is zero, set closes.
         trip_q.rampOpen <= !floatReg_q[IDX_RAMP][FLOAT_SIGN]
            && (floatReg_q[IDX_RAMP] != FLOAT_ZERO);
         trip_q.rampRate <= floatReg_q[IDX_RAMP];
      end
   end

   // Scaling limits follow the control variable for every source.
   always_comb begin
      cmd_d = cmd_q;
      cmd_d.source = intReg_q[IDX_SPSRC][1:0];
      cmd_d.isSetpoint = (mode_q == MODE_AUTO);
      cmd_d.isFloat = 1'b0;
      cmd_d.scaleMin = FLOAT_ZERO;
      case (intReg_q[IDX_CVSEL])
         CV_LIQUID: cmd_d.scaleMax = floatReg_q[IDX_LIQ_FS];
         CV_UPSTREAM: cmd_d.scaleMax = floatReg_q[IDX_UP_FS];
         CV_DOWNSTREAM: cmd_d.scaleMax = floatReg_q[IDX_DN_FS];
         CV_DELTA: cmd_d.scaleMax = floatReg_q[IDX_DP_FS];
         CV_TEMPERATURE: begin
            cmd_d.scaleMax = floatReg_q[IDX_TEMP_FS];
            cmd_d.scaleMin = floatReg_q[IDX_TEMP_MIN];
         end
         CV_GAS: cmd_d.scaleMax = floatReg_q[IDX_GAS_FS];
         CV_AUX: cmd_d.scaleMax = floatReg_q[IDX_AUX_FS];
         default: cmd_d.scaleMax = cmd_q.scaleMax;
      endcase
      case (intReg_q[IDX_SPSRC])
         SPSRC_ANALOG: begin
            // Full analog code is 100 percent; inversion mirrors the span.
            if (intReg_q[IDX_POL] == POL_INVERTED) begin
               cmd_d.value = {16'h0000, ANALOG_FULL - analogInput};
            end else begin
               cmd_d.value = {16'h0000, analogInput};
            end
         end
         SPSRC_DIGITAL: begin
            // Scaled integers pass through unchanged; limit to the 0..9999 span.
            if (mode_q == MODE_AUTO) begin
               cmd_d.value = {16'h0000, (intReg_q[IDX_DSP] > SCALED_MAX) ? SCALED_MAX
                  : intReg_q[IDX_DSP]};
            end else begin
               cmd_d.value = {16'h0000, (intReg_q[IDX_DPOS] > SCALED_MAX) ? SCALED_MAX
                  : intReg_q[IDX_DPOS]};
            end
         end
         SPSRC_REMOTE: begin
            cmd_d.isFloat = 1'b1;
            cmd_d.value = floatReg_q[IDX_RSP];
         end
         default: cmd_d.value = cmd_q.value;
      endcase
   end

   // Command freezes in test and during a trip; trip outputs carry the ramp.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cmd_q <= '0;
      end else if (!testMode && wd_q == WD_RUN) begin
         cmd_q <= cmd_d;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pv_q <= SCALED_MIN;
      end else if (!testMode) begin
         pv_q <= processVariable;
      end
   end

   assign regResp = resp_q;
   assign opMode = mode_q;
   assign command = cmd_q;
   assign trip = trip_q;
   assign indicatedPv = pv_q;

endmodule

/* tb/host_master_model.sv */
// Host model issuing one register request at a time.
`timescale 1ns/1ps
module host_master_model (
   input wire logic clk_sys,
   output valve_ctrl_pkg::reg_req_t regReq,
   input wire valve_ctrl_pkg::reg_resp_t regResp
);
   import valve_ctrl_pkg::*;
   initial regReq = '0;
   // Floats go whole at their first word.
   function automatic logic [1:0] wordsFor(input logic [15:0] a);
      return (a >= ADDR_AUX_INPUT_FULL_SCALE) ? WORDS_FLOAT : WORDS_INT;
   endfunction
   function automatic logic [15:0] scaled(input int pctTenths);
      return 16'(8 * (pctTenths + 125));
   endfunction
   task automatic xfer(input logic w, input logic [15:0] a, input logic [1:0] n,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk_sys);
      #1 regReq = '{1'b1, w, a, n, d};
      @(posedge clk_sys);
      #1 regReq = '0;
      for (int i = 0; i < 4 && regResp.valid !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      q = regResp.rdata;
      e = regResp.error;
   endtask
endmodule

/* tb/valve_mode_setpoint_control_chk.sv */
// Port checker for the valve control bank.
`timescale 1ns/1ps
module valve_mode_setpoint_control_chk #(
   parameter int SECOND_CYCLES = valve_ctrl_pkg::SECOND_CYCLES_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire valve_ctrl_pkg::reg_req_t regReq,
   input wire valve_ctrl_pkg::reg_resp_t regResp,
   input wire logic discreteInput,
   input wire logic [15:0] analogInput,
   input wire logic [15:0] processVariable,
   input wire valve_ctrl_pkg::op_mode_t opMode,
   input wire valve_ctrl_pkg::command_t command,
   input wire valve_ctrl_pkg::trip_t trip,
   input wire logic [15:0] indicatedPv
);
   import valve_ctrl_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic wrAuto, rdSp, rspReq, arm_q;
   logic [15:0] pvSnap_q;
   assign wrAuto = regReq.valid && regReq.write && regReq.addr == ADDR_DIGITAL_OPERATING_MODE
      && regReq.wdata[15:0] == DMODE_AUTO;
   assign rdSp = regReq.valid && !regReq.write && regReq.addr == ADDR_DIGITAL_SETPOINT;
   assign rspReq = regReq.valid && regReq.addr == ADDR_REMOTE_SETPOINT_COMMAND;
   // Armed only until the next request.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         arm_q <= 1'b0;
         pvSnap_q <= 16'h0000;
      end else if (regReq.valid) begin
         arm_q <= wrAuto;
         pvSnap_q <= processVariable;
      end
   end
   sequence quietInTest;
      !regReq.valid [*3] ##0 opMode == MODE_TEST;
   endsequence
   sequence rspAccepted;
      rspReq && regReq.write && regReq.words == WORDS_FLOAT && opMode != MODE_TEST
         ##1 regResp.valid && !regResp.error;
   endsequence
   a_mode_one_hot: assert property ($onehot(opMode))
      else $error("mode not one-hot");
   a_test_cmd_frozen: assert property (opMode == MODE_TEST |=> $stable(command))
      else $error("cmd moved in test");
   a_test_pv_frozen: assert property (opMode == MODE_TEST |=> $stable(indicatedPv))
      else $error("pv moved in test");
   a_test_sticks: assert property (quietInTest |=> opMode == MODE_TEST)
      else $error("left test unasked");
   a_bumpless_copy: assert property (arm_q && rdSp |=> $past(pvSnap_q) == regResp.rdata[15:0])
      else $error("no bumpless copy");
   a_float_one_word: assert property (rspReq && regReq.words == WORDS_INT |=> regResp.error)
      else $error("one-word float accepted");
   a_hold_not_ramp: assert property (trip.hold |-> !trip.ramp)
      else $error("hold and ramp together");
   a_ramp_after_hold: assert property ($rose(trip.ramp) |-> $past(trip.hold))
      else $error("ramp without hold");
   a_ramp_direction: assert property (trip.ramp |-> trip.rampOpen ==
      (!trip.rampRate[FLOAT_SIGN] && trip.rampRate != FLOAT_ZERO)) else $error("ramp direction");
   a_trip_cleared: assert property (rspAccepted |=> !trip.hold && !trip.ramp)
      else $error("trip not cleared");
endmodule
bind valve_mode_setpoint_control valve_mode_setpoint_control_chk #(.SECOND_CYCLES(SECOND_CYCLES))
   chk (.clk_sys(clk_sys), .reset(reset), .regReq(regReq), .regResp(regResp),
   .discreteInput(discreteInput), .analogInput(analogInput), .processVariable(processVariable),
   .opMode(opMode), .command(command), .trip(trip), .indicatedPv(indicatedPv));

/* tb/tb_valve_mode_setpoint_control.sv */
// Bench for the valve control bank.
`timescale 1ns/1ps
module tb_valve_mode_setpoint_control;
   import valve_ctrl_pkg::*;
   localparam int SEC = 4;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic discreteInput = 1'b0;
   logic [15:0] analogInput = 16'h4000;
   logic [15:0] processVariable = 16'h2222;
   reg_req_t regReq;
   reg_resp_t regResp;
   op_mode_t opMode;
   command_t command;
   trip_t trip;
   logic [15:0] indicatedPv;
   logic [31:0] rd;
   logic er;
   int n;
   int mismatches = 0;
   int checksDone = 0;
   logic [15:0] badA [3] = '{ADDR_REMOTE_SETPOINT_COMMAND, 16'h9f02, 16'h9c68};
   logic [1:0] badN [3] = '{WORDS_INT, WORDS_FLOAT, WORDS_INT};
   logic [15:0] fsA [7] = '{ADDR_LIQUID_FLOW_FULL_SCALE, ADDR_UPSTREAM_PRESSURE_FULL_SCALE,
      ADDR_DOWNSTREAM_PRESSURE_FULL_SCALE, ADDR_DELTA_PRESSURE_FULL_SCALE,
      ADDR_TEMPERATURE_FULL_SCALE, ADDR_GAS_FLOW_FULL_SCALE, ADDR_AUX_INPUT_FULL_SCALE};
   always #12.5 clk_sys = ~clk_sys;
   host_master_model host (.clk_sys(clk_sys), .regReq(regReq), .regResp(regResp));
   valve_mode_setpoint_control #(.SECOND_CYCLES(SEC)) uut (.clk_sys(clk_sys), .reset(reset),
      .regReq(regReq), .regResp(regResp), .discreteInput(discreteInput),
      .analogInput(analogInput), .processVariable(processVariable), .opMode(opMode),
      .command(command), .trip(trip), .indicatedPv(indicatedPv));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, host.wordsFor(a), d, rd, er);
   endtask
   task automatic rdChk(input logic [15:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, host.wordsFor(a), 32'h0, rd, er);
      cmp({er, rd[30:0]}, {1'b0, exp[30:0]});
   endtask
   task automatic modeChk(input op_mode_t m);
      tick(3);
      cmp(32'(opMode), 32'(m));
   endtask
   task automatic waitTrip(input bit ramp);
      n = 0;
      while (((ramp ? trip.ramp : trip.hold) !== 1'b1) && n < 40) begin
         tick(1);
         n++;
      end
   endtask
   task automatic tallyAndFinish();
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      tallyAndFinish();
   end
   initial begin
      tick(2);
      reset = 1'b0;
      modeChk(MODE_TEST);
      rdChk(ADDR_ANALOG_INPUT_POLARITY, {16'h0, POL_NORMAL});
      wr(ADDR_DIGITAL_SETPOINT, 32'h0064);
      rdChk(ADDR_DIGITAL_SETPOINT, 32'h0);
      cmp(32'(indicatedPv), 32'h0);
      for (int i = 0; i < 3; i++) begin
         host.xfer(1'b0, badA[i], badN[i], 32'h0, rd, er);
         cmp(32'(er), 32'h1);
      end
      wr(ADDR_SETPOINT_SOURCE_SELECT, {16'h0, SPSRC_DIGITAL});
      wr(ADDR_DIGITAL_OPERATING_MODE, {16'h0, DMODE_AUTO});
      modeChk(MODE_AUTO);
      rdChk(ADDR_DIGITAL_SETPOINT, 32'h2222);
      wr(ADDR_DIGITAL_SETPOINT, {16'h0, host.scaled(500)});
      tick(3);
      cmp(command.value, 32'd5000);
      processVariable = 16'h0777;
      wr(ADDR_DIGITAL_OPERATING_MODE, {16'h0, DMODE_AUTO});
      rdChk(ADDR_DIGITAL_SETPOINT, 32'h0777);
      wr(ADDR_DIGITAL_OPERATING_MODE, {16'h0, DMODE_MANUAL});
      wr(ADDR_DIGITAL_POSITION_COMMAND, 32'h4e20);
      modeChk(MODE_MANUAL);
      cmp({command.value[30:0], command.isSetpoint}, {31'h270f, 1'b0});
      wr(ADDR_SETPOINT_SOURCE_SELECT, {16'h0, SPSRC_ANALOG});
      wr(ADDR_ANALOG_INPUT_POLARITY, {16'h0, POL_INVERTED});
      modeChk(MODE_MANUAL);
      cmp(command.value, 32'hbfff);
      for (int i = 0; i < 7; i++) wr(fsA[i], 32'h4100_0000 + i);
      wr(ADDR_TEMPERATURE_MINIMUM_SCALE, 32'hc120_0000);
      for (int i = 0; i < 7; i++) begin
         wr(ADDR_CONTROL_VARIABLE_SELECT, 32'(i + 1));
         tick(3);
         cmp(command.scaleMax, 32'h4100_0000 + i);
         cmp(command.scaleMin, (i == 4) ? 32'hc120_0000 : FLOAT_ZERO);
      end
      wr(ADDR_MODE_SOURCE_SELECT, {16'h0, MSRC_DISCRETE});
      for (int i = 1; i >= 0; i--) begin
         discreteInput = i[0];
         modeChk(i[0] ? MODE_AUTO : MODE_MANUAL);
      end
      wr(ADDR_MODE_SOURCE_SELECT, {16'h0, MSRC_REMOTE});
      processVariable = 16'h0555;
      wr(ADDR_REMOTE_OPERATING_MODE, RMODE_AUTO);
      modeChk(MODE_AUTO);
      rdChk(ADDR_DIGITAL_SETPOINT, 32'h0555);
      processVariable = 16'h0666;
      wr(ADDR_REMOTE_OPERATING_MODE, RMODE_AUTO);
      rdChk(ADDR_DIGITAL_SETPOINT, 32'h0555);
      wr(ADDR_REMOTE_TIMEOUT_SECONDS, 32'h2);
      wr(ADDR_TRIP_HOLD_SECONDS, 32'h1);
      wr(ADDR_TRIP_RAMP_RATE, 32'hbf80_0000);
      wr(ADDR_SETPOINT_SOURCE_SELECT, {16'h0, SPSRC_REMOTE});
      wr(ADDR_REMOTE_SETPOINT_COMMAND, 32'h4248_0000);
      waitTrip(1'b0);
      cmp(32'(n >= 5 && n <= 11), 32'h1);
      cmp({command.isFloat, command.value[30:0]}, 32'hc248_0000);
      waitTrip(1'b1);
      cmp(32'(n >= 3 && n <= 5 && !trip.rampOpen), 32'h1);
      wr(ADDR_REMOTE_SETPOINT_COMMAND, 32'h4248_0000);
      tick(2);
      cmp(32'({trip.hold, trip.ramp}), 32'h0);
      tallyAndFinish();
   end
endmodule
